//--- logic/scbp_pkg.sv
`default_nettype none
package scbp_pkg;
   // Register indices on A6..A0 while A7 is low
   localparam logic [6:0]  REG_SWITCH_CONTROL    = 7'h00;
   localparam logic [6:0]  REG_INTERFACE_MODE    = 7'h01;
   localparam logic [15:0] SWITCH_CONTROL_RESET  = 16'h0000;
   localparam logic [15:0] INTERFACE_MODE_RESET  = 16'h0000;
   // Field positions, switch_control
   localparam int          STREAM_SELECT_LSB     = 0;
   localparam int          STREAM_SELECT_W       = 4;
   localparam int          MEMORY_SELECT_BIT     = 4;
   localparam int          BLOCK_PROG_ARM_BIT    = 5;
   localparam int          CONTROL_W             = 6;
   // Field positions, interface_mode_select
   localparam int          RATE_SELECT_LSB       = 0;
   localparam int          FRAME_EVAL_START_BIT  = 2;
   localparam int          OUTPUT_STANDBY_BIT    = 3;
   localparam int          BLOCK_PROG_BEGIN_BIT  = 4;
   localparam int          BLOCK_FILL_VALUE_LSB  = 5;
   localparam int          BLOCK_FILL_VALUE_W    = 5;
   localparam int          MODE_W                = 10;
   // Rate codes
   localparam logic [1:0]  RATE_2M               = 2'h0;
   localparam logic [1:0]  RATE_4M               = 2'h1;
   localparam logic [1:0]  RATE_8M               = 2'h2;
   // Connection memory geometry
   localparam int          NUM_STREAMS           = 16;
   localparam int          CHAN_W                = 7;
   localparam int          CM_ADDR_W             = 11;
   localparam int          CM_DATA_W             = 16;
   localparam logic [10:0] CM_LAST_ADDR          = 11'h7FF;
   localparam logic [10:0] CM_FILL_LOW           = 11'h000;
   // Timing: block fill must finish inside two frames
   localparam int          CLK_PERIOD_NS         = 50;
   localparam int          FRAME_NS              = 125000;
   localparam int          FILL_LIMIT_CYCLES     = (2 * FRAME_NS) / CLK_PERIOD_NS;
   // Host access sequencer
   typedef enum logic [1:0] {
      SCBP_BUS_IDLE = 2'b00,
      SCBP_BUS_READ = 2'b01,
      SCBP_BUS_DONE = 2'b10
   } scbp_bus_state_t;
endpackage
`default_nettype wire

//--- logic/scbp_out_ctl.sv
`timescale 1ns/1ns
`default_nettype none
module scbp_out_ctl (
   input  wire logic        mclk_in,
   input  wire logic        reset_in,
   input  wire logic [15:0] chan_oe_in,
   input  wire logic        drive_enable_pin_in,
   input  wire logic        output_standby_in,
   output logic      [15:0] drv_oe_n_out
);
   typedef struct packed {
      logic        pin_s1;
      logic        pin_s2;
      logic [15:0] oe_n;
   } scbp_oc_state_t;

   scbp_oc_state_t st;
   scbp_oc_state_t next_st;
   logic [15:0]    drive;

   genvar g;
   generate
      for (g = 0; g < scbp_pkg::NUM_STREAMS; g = g + 1) begin : g_stream
         // Channel bit low forces high impedance whatever the global controls say
         assign drive[g] = chan_oe_in[g] & (st.pin_s2 | output_standby_in); // [R01] [R02]
      end
   endgenerate

   always_comb begin
      next_st        = st;
      next_st.pin_s1 = drive_enable_pin_in;
      next_st.pin_s2 = st.pin_s1;
      next_st.oe_n   = ~drive;
   end

   always_ff @(posedge mclk_in) begin
      if (reset_in) begin
         st <= '{pin_s1: 1'b0, pin_s2: 1'b0, oe_n: 16'hFFFF};
      end else begin
         st <= next_st;
      end
   end

   assign drv_oe_n_out = st.oe_n;
endmodule
`default_nettype wire

//--- logic/scbp_top.sv
// Functional notes
// [R01] Channel enable bit low forces high impedance
// [R02] Else drive unless pin and standby low
// [R03] Host writes zero to control bits 15..6
// [R04] Arm bit enables block fill of bits 15..11
// [R05] Memory select steers reads; writes hit connection
// [R06] Data memory is never written by host
// [R07] Channel decode width follows rate select
// [R08] Fill value goes to bits 15..11
// [R09] Fill clears bits 10..0
// [R10] Fill starts on begin bit rising edge
// [R11] Host writes begin and fill value together
// [R12] Fill completes within two frames
// [R13] Begin bit self-clears when fill completes
// [R14] Clearing begin or arm aborts fill
// [R15] Host leaves mode bits alone two frames
// [R16] A7 low registers, A7 high memories
// [R17] Stream select picks memory subsection
// [R18] Rate codes 2, 4, 8 Mb/s; 11 reserved
// [R19] Fill walks every location in sequence
// [R20] Reset clears registers, idles fill engine
`timescale 1ns/1ns
`default_nettype none
module scbp_top (
   input  wire logic        mclk_in,
   input  wire logic        reset_in,
   input  wire logic        cs_n_in,
   input  wire logic        ds_n_in,
   input  wire logic        rw_in,
   input  wire logic [7:0]  addr_in,
   input  wire logic [15:0] wdata_in,
   output logic      [15:0] rdata_out,
   output logic             data_oe_n_out,
   output logic             ack_n_out,
   output logic             cm_we_out,
   output logic             mem_rd_out,
   output logic      [10:0] cm_addr_out,
   output logic      [15:0] cm_wdata_out,
   input  wire logic [15:0] cm_rdata_in,
   input  wire logic [15:0] dm_rdata_in,
   input  wire logic [15:0] chan_oe_in,
   input  wire logic        drive_enable_pin_in,
   output logic      [15:0] drv_oe_n_out,
   output logic      [1:0]  rate_select_out,
   output logic             frame_eval_start_out,
   output logic             block_prog_busy_out
);
   localparam int BUS_W = 27;

   typedef struct packed {
      logic [BUS_W-1:0]                s1;
      logic [BUS_W-1:0]                s2;
      scbp_pkg::scbp_bus_state_t       bstate;
      logic [5:0]                      switch_control;
      logic [9:0]                      interface_mode_select;
      logic                            busy;
      logic [10:0]                     fill_addr;
      logic                            cm_we;
      logic                            mem_rd;
      logic [10:0]                     cm_addr;
      logic [15:0]                     cm_wdata;
      logic                            rd_data_mem;
      logic [15:0]                     rdata;
      logic                            data_oe_n;
      logic                            ack_n;
   } scbp_state_t;

   scbp_state_t st;
   scbp_state_t next_st;

   logic        strobe;
   logic        host_rw;
   logic [7:0]  host_addr;
   logic [15:0] host_wdata;
   logic [6:0]  chan;
   logic [10:0] mem_addr;
   logic [9:0]  new_mode;
   logic [5:0]  new_ctrl;
   logic        begin_now;
   logic        arm_now;

   // Only the second stage of the pin synchroniser is looked at
   assign strobe     = ~st.s2[26] & ~st.s2[25];
   assign host_rw    = st.s2[24];
   assign host_addr  = st.s2[23:16];
   assign host_wdata = st.s2[15:0];
   assign new_mode   = host_wdata[scbp_pkg::MODE_W-1:0];
   assign new_ctrl   = host_wdata[scbp_pkg::CONTROL_W-1:0]; // [R03]
   assign begin_now  = st.interface_mode_select[scbp_pkg::BLOCK_PROG_BEGIN_BIT];
   assign arm_now    = st.switch_control[scbp_pkg::BLOCK_PROG_ARM_BIT];

   always_comb begin
      // Reserved rate code decodes as the widest channel field
      unique case (st.interface_mode_select[1:0]) // [R18]
         scbp_pkg::RATE_2M: chan = {2'h0, host_addr[4:0]}; // [R07]
         scbp_pkg::RATE_4M: chan = {1'h0, host_addr[5:0]}; // [R07]
         default:           chan = host_addr[6:0];         // [R07]
      endcase
   end

   assign mem_addr = {st.switch_control[scbp_pkg::STREAM_SELECT_LSB +: scbp_pkg::STREAM_SELECT_W], chan}; // [R17]

   always_comb begin
      next_st        = st;
      next_st.s1     = {cs_n_in, ds_n_in, rw_in, addr_in, wdata_in};
      next_st.s2     = st.s1;
      next_st.cm_we  = 1'b0;
      next_st.mem_rd = 1'b0;

      // One location per clock: 2048 cycles, well inside two frames
      if (st.busy) begin
         next_st.cm_we     = 1'b1; // [R19]
         next_st.cm_addr   = st.fill_addr; // [R19]
         next_st.cm_wdata  = {st.interface_mode_select[scbp_pkg::BLOCK_FILL_VALUE_LSB +:
                                                        scbp_pkg::BLOCK_FILL_VALUE_W], // [R08]
                              scbp_pkg::CM_FILL_LOW}; // [R09]
         next_st.fill_addr = st.fill_addr + 11'h001;
         if (st.fill_addr == scbp_pkg::CM_LAST_ADDR) begin // [R12]
            next_st.busy = 1'b0;
            next_st.interface_mode_select[scbp_pkg::BLOCK_PROG_BEGIN_BIT] = 1'b0; // [R13]
         end
      end

      unique case (st.bstate)
         scbp_pkg::SCBP_BUS_IDLE: begin
            if (strobe) begin
               if (!host_addr[7]) begin // [R16]
                  next_st.rdata       = 16'h0000;
                  next_st.data_oe_n   = ~host_rw;
                  next_st.ack_n       = 1'b0;
                  next_st.bstate      = scbp_pkg::SCBP_BUS_DONE;
                  if (host_addr[6:0] == scbp_pkg::REG_SWITCH_CONTROL) begin
                     next_st.rdata = {10'h000, st.switch_control};
                     if (!host_rw) begin
                        next_st.switch_control = new_ctrl;
                        // Dropping the arm bit mid-fill abandons the pass
                        if (begin_now && !new_ctrl[scbp_pkg::BLOCK_PROG_ARM_BIT]) begin // [R14]
                           next_st.busy = 1'b0;
                           next_st.interface_mode_select[scbp_pkg::BLOCK_PROG_BEGIN_BIT] = 1'b0;
                        end
                     end
                  end else if (host_addr[6:0] == scbp_pkg::REG_INTERFACE_MODE) begin
                     next_st.rdata = {6'h00, st.interface_mode_select};
                     if (!host_rw) begin
                        // Fill value and begin arrive in the same write
                        next_st.interface_mode_select = new_mode; // [R11]
                        if (!begin_now && new_mode[scbp_pkg::BLOCK_PROG_BEGIN_BIT]) begin // [R10]
                           if (arm_now) begin // [R04]
                              next_st.busy      = 1'b1;
                              next_st.fill_addr = 11'h000;
                           end
                        end else if (begin_now && !new_mode[scbp_pkg::BLOCK_PROG_BEGIN_BIT]) begin
                           next_st.busy = 1'b0; // [R14]
                        end
                     end
                  end
               end else if (!st.busy) begin
                  // Memory access waits while the fill engine owns the port
                  if (!host_rw) begin
                     next_st.cm_we    = 1'b1; // [R06]
                     next_st.cm_addr  = mem_addr;
                     next_st.cm_wdata = host_wdata;
                     next_st.ack_n    = 1'b0;
                     next_st.bstate   = scbp_pkg::SCBP_BUS_DONE;
                  end else begin
                     next_st.mem_rd      = 1'b1;
                     next_st.cm_addr     = mem_addr;
                     next_st.rd_data_mem = st.switch_control[scbp_pkg::MEMORY_SELECT_BIT]; // [R05]
                     next_st.bstate      = scbp_pkg::SCBP_BUS_READ;
                  end
               end
            end
         end
         scbp_pkg::SCBP_BUS_READ: begin
            next_st.rdata     = st.rd_data_mem ? dm_rdata_in : cm_rdata_in; // [R05]
            next_st.data_oe_n = 1'b0;
            next_st.ack_n     = 1'b0;
            next_st.bstate    = scbp_pkg::SCBP_BUS_DONE;
         end
         scbp_pkg::SCBP_BUS_DONE: begin
            if (!strobe) begin
               next_st.data_oe_n = 1'b1;
               next_st.ack_n     = 1'b1;
               next_st.bstate    = scbp_pkg::SCBP_BUS_IDLE;
            end
         end
         default: begin
            next_st.bstate = scbp_pkg::SCBP_BUS_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk_in) begin
      if (reset_in) begin
         st                       <= '0; // [R20]
         st.s1                    <= 27'h7FFFFFF;
         st.s2                    <= 27'h7FFFFFF;
         st.bstate                <= scbp_pkg::SCBP_BUS_IDLE;
         st.switch_control        <= scbp_pkg::SWITCH_CONTROL_RESET[5:0]; // [R20]
         st.interface_mode_select <= scbp_pkg::INTERFACE_MODE_RESET[9:0]; // [R20]
         st.data_oe_n             <= 1'b1;
         st.ack_n                 <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   scbp_out_ctl u_out_ctl (
      .mclk_in             (mclk_in),
      .reset_in            (reset_in),
      .chan_oe_in          (chan_oe_in),
      .drive_enable_pin_in (drive_enable_pin_in),
      .output_standby_in   (st.interface_mode_select[scbp_pkg::OUTPUT_STANDBY_BIT]),
      .drv_oe_n_out        (drv_oe_n_out)
   );

   assign rdata_out            = st.rdata;
   assign data_oe_n_out        = st.data_oe_n;
   assign ack_n_out            = st.ack_n;
   assign cm_we_out            = st.cm_we;
   assign mem_rd_out           = st.mem_rd;
   assign cm_addr_out          = st.cm_addr;
   assign cm_wdata_out         = st.cm_wdata;
   assign rate_select_out      = st.interface_mode_select[1:0];
   assign frame_eval_start_out = st.interface_mode_select[scbp_pkg::FRAME_EVAL_START_BIT];
   assign block_prog_busy_out  = st.busy;
endmodule
`default_nettype wire

//--- verification/scbp_top_chk.sv
`timescale 1ns/1ns
`default_nettype none
module scbp_top_chk (
   input  wire logic        mclk_in,
   input  wire logic        reset_in,
   input  wire logic        ack_n_out,
   input  wire logic        data_oe_n_out,
   input  wire logic        cm_we_out,
   input  wire logic        mem_rd_out,
   input  wire logic [10:0] cm_addr_out,
   input  wire logic [15:0] cm_wdata_out,
   input  wire logic [15:0] chan_oe_in,
   input  wire logic [15:0] drv_oe_n_out,
   input  wire logic        block_prog_busy_out
);
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (reset_in);
   int busy_cnt;
   always_ff @(posedge mclk_in) begin
      if (reset_in || !block_prog_busy_out) busy_cnt <= 0;
      else busy_cnt <= busy_cnt + 1;
   end
   property p_oe_off; 1 |=> ((~drv_oe_n_out) & ~$past(chan_oe_in)) == 16'h0000; endproperty
   a_oe_off: assert property (p_oe_off) else $error("driver on with channel disabled");
   property p_fill_low; block_prog_busy_out && cm_we_out |-> cm_wdata_out[10:0] == 11'h000; endproperty
   a_fill_low: assert property (p_fill_low) else $error("fill low bits not zero");
   property p_fill_seq;
      cm_we_out && $past(cm_we_out) && block_prog_busy_out |-> cm_addr_out == $past(cm_addr_out) + 11'h001;
   endproperty
   a_fill_seq: assert property (p_fill_seq) else $error("fill address skipped");
   property p_fill_time; block_prog_busy_out |-> busy_cnt < scbp_pkg::FILL_LIMIT_CYCLES; endproperty
   a_fill_time: assert property (p_fill_time) else $error("fill overran two frames");
   property p_start; $rose(block_prog_busy_out) |-> $fell(ack_n_out); endproperty
   a_start: assert property (p_start) else $error("fill began without a host write");
   property p_rd; mem_rd_out |-> ack_n_out ##1 (!ack_n_out && !data_oe_n_out); endproperty
   a_rd: assert property (p_rd) else $error("memory read answer late");
   property p_wr;
      $rose(cm_we_out) && !block_prog_busy_out && !$past(block_prog_busy_out) |-> $fell(ack_n_out) ##1 !cm_we_out;
   endproperty
   a_wr: assert property (p_wr) else $error("host memory write not a single acked pulse");
   property p_oe_rd; !data_oe_n_out |-> !ack_n_out; endproperty
   a_oe_rd: assert property (p_oe_rd) else $error("read data driven without ack");
   property p_rst;
      disable iff (1'b0) reset_in |=> ack_n_out && data_oe_n_out && !block_prog_busy_out && drv_oe_n_out == 16'hFFFF;
   endproperty
   a_rst: assert property (p_rst) else $error("outputs not idle in reset");
   c_fill: cover property ($rose(block_prog_busy_out));
   c_rd: cover property (mem_rd_out);
   c_wr: cover property (cm_we_out && !block_prog_busy_out);
endmodule
`default_nettype wire

//--- verification/scbp_mem_model.sv
`timescale 1ns/1ns
`default_nettype none
module scbp_mem_model (
   input  wire logic        mclk_in,
   input  wire logic        cm_we_in,
   input  wire logic        mem_rd_in,
   input  wire logic [10:0] cm_addr_in,
   input  wire logic [15:0] cm_wdata_in,
   output logic      [15:0] cm_rdata_out,
   output logic      [15:0] dm_rdata_out
);
   logic [15:0] cm [0:2047];
   logic [15:0] scramble = 16'hA5C3;
   always @(posedge mclk_in) begin
      if (cm_we_in) begin
         cm[cm_addr_in] <= cm_wdata_in;
      end
      scramble <= ~scramble;
   end
   // The block samples at the edge that ends the read pulse, so the answer is asynchronous
   // Scrambled outside the read slot so a late or early sample is caught
   assign cm_rdata_out = mem_rd_in ? cm[cm_addr_in] : scramble;
   assign dm_rdata_out = mem_rd_in ? {5'h15, cm_addr_in} : ~scramble;
endmodule
`default_nettype wire

//--- verification/switch_control_block_program_tb.sv
`timescale 1ns/1ns
`default_nettype none
module switch_control_block_program_tb;
   logic        mclk_in = 1'b0, reset_in = 1'b1, cs_n = 1'b1, ds_n = 1'b1, rw = 1'b1, pin = 1'b0;
   logic [7:0]  addr = 8'h00;
   logic [15:0] wdata = 16'h0000, chan_oe = 16'h0000, q, d;
   logic [10:0] wa;
   logic [6:0]  m;
   wire logic [15:0] rdata, cm_rdata, dm_rdata, cm_wdata, drv_oe_n;
   wire logic [10:0] cm_addr;
   wire logic [1:0]  rate;
   wire logic        data_oe_n, ack_n, cm_we, mem_rd, eval, busy;
   int          mismatches = 0, comparisons = 0, seed = 32'h9709, k;
   always #25 mclk_in = ~mclk_in;
   scbp_top i_scbp_top (.mclk_in(mclk_in), .reset_in(reset_in), .cs_n_in(cs_n), .ds_n_in(ds_n),
      .rw_in(rw), .addr_in(addr), .wdata_in(wdata), .rdata_out(rdata), .data_oe_n_out(data_oe_n),
      .ack_n_out(ack_n), .cm_we_out(cm_we), .mem_rd_out(mem_rd), .cm_addr_out(cm_addr),
      .cm_wdata_out(cm_wdata), .cm_rdata_in(cm_rdata), .dm_rdata_in(dm_rdata), .chan_oe_in(chan_oe),
      .drive_enable_pin_in(pin), .drv_oe_n_out(drv_oe_n), .rate_select_out(rate),
      .frame_eval_start_out(eval), .block_prog_busy_out(busy));
   scbp_mem_model i_scbp_mem_model (.mclk_in(mclk_in), .cm_we_in(cm_we), .mem_rd_in(mem_rd),
      .cm_addr_in(cm_addr), .cm_wdata_in(cm_wdata), .cm_rdata_out(cm_rdata), .dm_rdata_out(dm_rdata));
   task stop_test;
      if (mismatches == 0 && comparisons > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task chk(input logic [15:0] g, input logic [15:0] e);
      comparisons++;
      if (g !== e) begin
         mismatches++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   // Entered at a falling edge; holds the request until ack, then releases
   task acc(input logic r, input logic [7:0] a, input logic [15:0] v);
      int n;
      cs_n = 1'b0; ds_n = 1'b0; rw = r; addr = a; wdata = v; n = 0;
      while (ack_n !== 1'b0 && n < 3000) begin @(negedge mclk_in); n++; end
      if (n == 3000) mismatches++;
      q = rdata; wa = cm_addr; cs_n = 1'b1; ds_n = 1'b1; n = 0;
      while (ack_n !== 1'b1 && n < 10) begin @(negedge mclk_in); n++; end
      if (n == 10) mismatches++;
      @(negedge mclk_in);
   endtask
   initial begin
      repeat (8) @(negedge mclk_in);
      reset_in = 1'b0;
      @(negedge mclk_in);
      for (k = 0; k < 3; k++) begin
         acc(1'b1, k[7:0], 16'h0000);
         chk(q, 16'h0000);
      end
      for (k = 0; k < 3; k++) begin
         m = 7'h7F >> (2 - k);
         d = 16'($random(seed));
         acc(1'b0, 8'h01, {13'h0, k[0], k[1:0]});
         chk({13'h0, eval, rate}, {13'h0, k[0], k[1:0]});
         acc(1'b0, 8'h00, {12'h0, d[3:0]});
         acc(1'b0, {1'b1, d[14:8]}, d);
         chk({5'h0, wa}, {5'h0, d[3:0], d[14:8] & m});
         acc(1'b1, {1'b1, d[14:8] ^ ~m}, 16'h0000);
         chk(q, d);
      end
      acc(1'b0, 8'h00, {11'h0, 1'b1, d[3:0]});
      acc(1'b1, {1'b1, d[14:8]}, 16'h0000);
      chk(q, {5'h15, d[3:0], d[14:8]});
      acc(1'b0, {1'b1, d[14:8]}, ~d);
      acc(1'b0, 8'h00, {12'h0, d[3:0]});
      acc(1'b1, {1'b1, d[14:8]}, 16'h0000);
      chk(q, ~d);
      d = 16'($random(seed));
      acc(1'b0, 8'h00, 16'h0020);
      acc(1'b0, 8'h01, {6'h0, d[4:0], 5'h12});
      k = 0;
      // Only reads while begin is high, so the other mode bits stay put
      do begin
         acc(1'b1, 8'h01, 16'h0000);
         k++;
      end while (q[4] && k < 2000);
      chk(q, {6'h0, d[4:0], 5'h02});
      acc(1'b0, 8'h00, 16'h002F);
      acc(1'b1, 8'hFF, 16'h0000);
      chk(q, {d[4:0], 11'h000});
      acc(1'b0, 8'h01, {6'h0, ~d[4:0], 5'h12});
      acc(1'b0, 8'h01, {6'h0, ~d[4:0], 5'h02});
      chk({15'h0, busy}, 16'h0000);
      acc(1'b1, 8'hFF, 16'h0000);
      chk(q, {d[4:0], 11'h000});
      // Abort by dropping the arm bit instead of the begin bit
      acc(1'b0, 8'h01, {6'h0, d[4:0], 5'h12});
      acc(1'b0, 8'h00, 16'h000F);
      chk({15'h0, busy}, 16'h0000);
      acc(1'b1, 8'h01, 16'h0000);
      chk(q, {6'h0, d[4:0], 5'h02});
      // Reset in the middle of a fill
      acc(1'b0, 8'h00, 16'h002F);
      acc(1'b0, 8'h01, {6'h0, ~d[4:0], 5'h12});
      chk({15'h0, busy}, 16'h0001);
      reset_in = 1'b1;
      repeat (2) @(negedge mclk_in);
      reset_in = 1'b0;
      @(negedge mclk_in);
      chk({15'h0, busy}, 16'h0000);
      for (k = 0; k < 2; k++) begin
         acc(1'b1, k[7:0], 16'h0000);
         chk(q, 16'h0000);
      end
      acc(1'b0, 8'h00, 16'h000F);
      acc(1'b0, 8'h01, 16'h0012);
      repeat (5) @(negedge mclk_in);
      chk({15'h0, busy}, 16'h0000);
      acc(1'b1, 8'h01, 16'h0000);
      chk(q, 16'h0012);
      // Begin already high: arming and rewriting it is no rising edge
      acc(1'b0, 8'h00, 16'h002F);
      acc(1'b0, 8'h01, 16'h0012);
      repeat (5) @(negedge mclk_in);
      chk({15'h0, busy}, 16'h0000);
      for (k = 0; k < 4; k++) begin
         pin = k[1];
         chan_oe = 16'($random(seed));
         acc(1'b0, 8'h01, {12'h0, k[0], 3'h2});
         repeat (4) @(negedge mclk_in);
         chk(drv_oe_n, ~(chan_oe & {16{k[1] | k[0]}}));
      end
      stop_test;
   end
   initial begin
      #3000000;
      mismatches++;
      stop_test;
   end
endmodule
bind scbp_top scbp_top_chk i_scbp_top_chk (.mclk_in(mclk_in), .reset_in(reset_in), .ack_n_out(ack_n_out),
   .data_oe_n_out(data_oe_n_out), .cm_we_out(cm_we_out), .mem_rd_out(mem_rd_out), .cm_addr_out(cm_addr_out),
   .cm_wdata_out(cm_wdata_out), .chan_oe_in(chan_oe_in), .drv_oe_n_out(drv_oe_n_out),
   .block_prog_busy_out(block_prog_busy_out));
`default_nettype wire
